//--- shared/fpt_consts.vh
// Constants for the flash protection and timing controller.
// Assumes inclusion by the design files only; definitions, no logic.
`ifndef FPT_CONSTS_VH
`define FPT_CONSTS_VH

// -----------------------------------------------------------------
// Array organisation
// -----------------------------------------------------------------
`define FPT_WORD_W 32
`define FPT_ADDR_W 13
`define FPT_NWORDS 2048
`define FPT_BLK_LSB 8
`define FPT_UNIT_LSB 9
`define FPT_UNITS 4
`define FPT_BLK_WORDS 256
`define FPT_ERASED 32'hffffffff

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define FPT_USEC_RESET 8'h31
`define FPT_PROG_US 16'h0014
`define FPT_ERASE_US 16'h0064

// -----------------------------------------------------------------
// Protection and commands
// -----------------------------------------------------------------
`define FPT_PROT_RESET 32'hffffffff
`define FPT_CMD_PROG 2'h1
`define FPT_CMD_ERASE 2'h2
`define FPT_CMD_COMMIT 2'h3
`define FPT_INT_PROG 0
`define FPT_INT_ACC 1

`endif

//--- rtl/fpt_array.v
// Flash array model: 2048 words of 32 bits, registered read data.
// Assumes one operation per cycle from the controller.
`include "fpt_consts.vh"

module fpt_array (
  // Clock
  input wire clk,
  // Read port
  input wire [`FPT_ADDR_W-3:0] rd_addr,
  output reg [`FPT_WORD_W-1:0] rd_data,
  // Write port
  input wire wr_en,
  input wire [`FPT_ADDR_W-3:0] wr_addr,
  input wire [`FPT_WORD_W-1:0] wr_data
);

  reg [`FPT_WORD_W-1:0] mem [0:`FPT_NWORDS-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

//--- rtl/fpt_ctrl.v
// Flash controller: protection checks, microsecond timing, program,
// erase and commit sequencing, interrupt status.
// Assumes one requester at a time, inputs on the same clock.
//
// Overview of operation
// - Erase works on one 1-KB block, leaving every bit at one.
// - Program writes one 32-bit word, only clearing ones to zeros.
// - Two adjacent erase blocks form one 2-KB protection unit.
// - Execute-only units answer instruction fetch only, refusing data reads.
// - Timing uses clocks-per-microsecond count, reset to safe maximum-rate value.
// - Two 32-bit protection registers, one bit per unit per policy.
// - Program-enable one permits change; zero refuses any change.
// - Read-enable zero allows execution only, no data reads.
// - Both bits zero: execute-only, no write, erase or read.
// - Program one, read zero: write, erase, execute, no data read.
// - Program zero, read one: read-only, no write or erase.
// - Both bits one: no restriction at all.
// - Data read of read-protected unit blocked with bus fault.
// - Change to program-protected unit suppressed; access interrupt if masked in.
// - Protection bits read one as delivered.
// - Writes to protection registers only clear bits.
// - Uncommitted clears return to one at power-on; committed persist only if RESET is high on the first clock.
// - Commit command stores one protection register non-volatilely, chosen by CMD_COMMIT_PE.
// - Finished program or erase raises programming interrupt event.
// - Writing one to clear register clears raw and masked status.
`include "fpt_consts.vh"

module fpt_ctrl (
  // Clock and reset
  input wire CLOCK,
  input wire RESET,
  // Read access
  input wire RD_REQ,
  input wire RD_FETCH,
  input wire [`FPT_ADDR_W-1:0] RD_ADDR,
  output reg RD_VALID,
  output reg RD_FAULT,
  output reg [`FPT_WORD_W-1:0] RD_DATA,
  // Program, erase and commit commands
  input wire CMD_REQ,
  input wire [1:0] CMD_OP,
  input wire [`FPT_ADDR_W-1:0] CMD_ADDR,
  input wire [`FPT_WORD_W-1:0] CMD_DATA,
  input wire CMD_COMMIT_PE,
  output reg CMD_BUSY,
  // Configuration
  input wire USEC_WR,
  input wire [7:0] USEC_DATA,
  output reg [7:0] USEC_RELOAD,
  input wire PE_WR,
  input wire [31:0] PE_DATA,
  input wire RE_WR,
  input wire [31:0] RE_DATA,
  output reg [31:0] PROGRAM_ENABLE,
  output reg [31:0] READ_ENABLE,
  // Interrupts
  input wire [1:0] INT_MASK,
  input wire [1:0] INT_CLEAR,
  output reg [1:0] RAW_INT,
  output reg [1:0] MASKED_INT
);

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_PROG = 2'h1;
  localparam ST_ERASE = 2'h2;
  localparam ST_RMW = 2'h3;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] usec_reg;
  reg [15:0] us_left_reg;
  reg [`FPT_ADDR_W-3:0] addr_reg;
  reg [`FPT_WORD_W-1:0] data_reg;
  reg [7:0] cnt_reg;
  // Non-volatile copies survive RESET; only power-up init and the commit command set them.
  reg [31:0] nv_pe_reg = `FPT_PROT_RESET;
  reg [31:0] nv_re_reg = `FPT_PROT_RESET;
  reg rd_pend_reg;
  reg rd_fault_pend_reg;
  reg power_up_reg = 1'b1;

  wire [`FPT_WORD_W-1:0] arr_rd;
  reg arr_wr;
  reg [`FPT_ADDR_W-3:0] arr_wa;
  reg [`FPT_WORD_W-1:0] arr_wd;
  reg [`FPT_ADDR_W-3:0] arr_ra;

  wire [1:0] rd_unit = RD_ADDR[`FPT_ADDR_W-1:`FPT_UNIT_LSB+2];
  wire [1:0] cmd_unit = CMD_ADDR[`FPT_ADDR_W-1:`FPT_UNIT_LSB+2];
  wire rd_allowed = RD_FETCH | READ_ENABLE[rd_unit];
  wire cmd_allowed = PROGRAM_ENABLE[cmd_unit];
  wire idle = (state_reg == ST_IDLE);
  wire start = CMD_REQ & idle;
  wire is_change = (CMD_OP == `FPT_CMD_PROG) | (CMD_OP == `FPT_CMD_ERASE);
  wire us_tick = (cnt_reg == 8'h00);
  wire done = (state_reg == ST_PROG || state_reg == ST_ERASE) &&
    us_tick && (us_left_reg == 16'h0000);
  wire erase_last = (addr_reg[`FPT_BLK_LSB-1:0] == 8'hff);
  wire acc_evt = start & is_change & ~cmd_allowed;
  wire prog_evt = done & (state_reg == ST_PROG | erase_last);

  fpt_array u_array (
    .clk(CLOCK),
    .rd_addr(arr_ra),
    .rd_data(arr_rd),
    .wr_en(arr_wr),
    .wr_addr(arr_wa),
    .wr_data(arr_wd)
  );

  // -----------------------------------------------------------------
  // Array port steering
  // -----------------------------------------------------------------
  always @* begin
    arr_ra = RD_ADDR[`FPT_ADDR_W-1:2];
    if (start) begin
      arr_ra = CMD_ADDR[`FPT_ADDR_W-1:2];
    end
    arr_wr = 1'b0;
    arr_wa = addr_reg;
    arr_wd = data_reg;
    if (done && state_reg == ST_PROG) begin
      arr_wr = 1'b1;
      arr_wd = data_reg;
    end else if (done) begin
      arr_wr = 1'b1;
      arr_wd = `FPT_ERASED;
    end
  end

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start && is_change && cmd_allowed) begin
          state_next = (CMD_OP == `FPT_CMD_PROG) ? ST_RMW : ST_ERASE;
        end
      end
      ST_RMW: state_next = ST_PROG;
      ST_PROG: begin
        if (done) begin
          state_next = ST_IDLE;
        end
      end
      ST_ERASE: begin
        if (done && erase_last) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      state_reg <= ST_IDLE;
      usec_reg <= `FPT_USEC_RESET;
      us_left_reg <= 16'h0000;
      cnt_reg <= 8'h00;
      addr_reg <= {(`FPT_ADDR_W-2){1'b0}};
      data_reg <= {`FPT_WORD_W{1'b0}};
      CMD_BUSY <= 1'b0;
      USEC_RELOAD <= `FPT_USEC_RESET;
    end else begin
      state_reg <= state_next;
      CMD_BUSY <= (state_next != ST_IDLE);
      if (USEC_WR) begin
        usec_reg <= USEC_DATA;
        USEC_RELOAD <= USEC_DATA;
      end
      // Microsecond prescaler: usec_reg+1 clocks per tick
      if (us_tick) begin
        cnt_reg <= usec_reg;
      end else begin
        cnt_reg <= cnt_reg - 8'h01;
      end
      if (us_tick && us_left_reg != 16'h0000) begin
        us_left_reg <= us_left_reg - 16'h0001;
      end
      if (start) begin
        addr_reg <= CMD_ADDR[`FPT_ADDR_W-1:2];
        data_reg <= CMD_DATA;
        if (CMD_OP == `FPT_CMD_ERASE) begin
          // Start at the first word of the 1-KB block
          addr_reg[`FPT_BLK_LSB-1:0] <= 8'h00;
        end
        us_left_reg <= (CMD_OP == `FPT_CMD_ERASE) ?
          `FPT_ERASE_US : `FPT_PROG_US;
      end else if (state_reg == ST_RMW) begin
        // Old word was read in the start cycle; merge it once here
        data_reg <= data_reg & arr_rd;
      end else if (done && state_reg == ST_ERASE && !erase_last) begin
        addr_reg <= addr_reg + 11'h001;
        us_left_reg <= 16'h0000;
      end
    end
  end

  // -----------------------------------------------------------------
  // Protection registers
  // -----------------------------------------------------------------
  // Power-up flag distinguishes power-on restore from a later RESET.
  always @(posedge CLOCK) begin
    power_up_reg <= 1'b0;
    if (start && CMD_OP == `FPT_CMD_COMMIT) begin
      if (CMD_COMMIT_PE) begin
        nv_pe_reg <= nv_pe_reg & PROGRAM_ENABLE;
      end else begin
        nv_re_reg <= nv_re_reg & READ_ENABLE;
      end
    end
  end

  always @(posedge CLOCK) begin
    if (RESET && power_up_reg) begin
      // Uncommitted clears are lost; committed ones come back
      PROGRAM_ENABLE <= nv_pe_reg;
      READ_ENABLE <= nv_re_reg;
    end else if (power_up_reg) begin
      PROGRAM_ENABLE <= `FPT_PROT_RESET;
      READ_ENABLE <= `FPT_PROT_RESET;
    end else begin
      if (PE_WR) begin
        PROGRAM_ENABLE <= PROGRAM_ENABLE & PE_DATA;
      end
      if (RE_WR) begin
        READ_ENABLE <= READ_ENABLE & RE_DATA;
      end
    end
  end

  // -----------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------
  // Reads share the array port; a read in a command start cycle is dropped
  // unanswered, so the caller must not read while CMD_REQ is accepted.
  always @(posedge CLOCK) begin
    if (RESET) begin
      rd_pend_reg <= 1'b0;
      rd_fault_pend_reg <= 1'b0;
      RD_VALID <= 1'b0;
      RD_FAULT <= 1'b0;
      RD_DATA <= {`FPT_WORD_W{1'b0}};
    end else begin
      rd_pend_reg <= RD_REQ & ~start;
      rd_fault_pend_reg <= RD_REQ & ~start & ~rd_allowed;
      RD_VALID <= rd_pend_reg;
      RD_FAULT <= rd_fault_pend_reg;
      // Refused data never reaches the bus
      RD_DATA <= (rd_pend_reg & ~rd_fault_pend_reg) ?
        arr_rd : {`FPT_WORD_W{1'b0}};
    end
  end

  // -----------------------------------------------------------------
  // Interrupt status
  // -----------------------------------------------------------------
  always @(posedge CLOCK) begin
    if (RESET) begin
      RAW_INT <= 2'h0;
      MASKED_INT <= 2'h0;
    end else begin
      // Set wins over a clear in the same cycle
      RAW_INT <= (RAW_INT & ~INT_CLEAR) | {acc_evt, prog_evt};
      MASKED_INT <= ((RAW_INT & ~INT_CLEAR) | {acc_evt, prog_evt}) &
        INT_MASK;
    end
  end

endmodule

//--- sim/fpt_ctrl_sva.sv
// Port checker for the flash protection and timing controller.
// Assumes one clock, synchronous active-high reset, bound by name.
module fpt_ctrl_sva (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Read access
  input wire logic RD_REQ,
  input wire logic RD_FETCH,
  input wire logic [12:0] RD_ADDR,
  input wire logic RD_VALID,
  input wire logic RD_FAULT,
  input wire logic [31:0] RD_DATA,
  // Commands and configuration
  input wire logic CMD_REQ,
  input wire logic [1:0] CMD_OP,
  input wire logic [12:0] CMD_ADDR,
  input wire logic CMD_BUSY,
  input wire logic USEC_WR,
  input wire logic [7:0] USEC_DATA,
  input wire logic [7:0] USEC_RELOAD,
  input wire logic [31:0] PROGRAM_ENABLE,
  input wire logic [31:0] READ_ENABLE,
  input wire logic [1:0] RAW_INT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // Command start steals the read slot
  wire take_rd = RD_REQ && !(CMD_REQ && !CMD_BUSY);
  wire take_pe = CMD_REQ && !CMD_BUSY && (CMD_OP == 2'h1 || CMD_OP == 2'h2);
  wire pe_ok = PROGRAM_ENABLE[CMD_ADDR[12:11]];
  wire re_ok = READ_ENABLE[RD_ADDR[12:11]];
  rd_latency_a: assert property (take_rd |-> ##2 RD_VALID)
    else $error("read answer not two cycles after request");
  fault_pair_a: assert property (RD_FAULT |-> RD_VALID && RD_DATA == 32'h0)
    else $error("fault without answer or with data");
  rd_block_a: assert property (take_rd && !RD_FETCH && !re_ok |-> ##2 RD_FAULT)
    else $error("data read of protected unit not faulted");
  fetch_ok_a: assert property (take_rd && RD_FETCH |-> ##2 !RD_FAULT)
    else $error("instruction fetch faulted");
  prog_refuse_a: assert property (take_pe && !pe_ok |=> !CMD_BUSY && RAW_INT[1])
    else $error("protected change not refused");
  prog_start_a: assert property (take_pe && pe_ok |=> CMD_BUSY)
    else $error("permitted change did not start");
  clear_only_a: assert property (1 |=> ((PROGRAM_ENABLE & ~$past(PROGRAM_ENABLE)) |
    (READ_ENABLE & ~$past(READ_ENABLE))) == 32'h0)
    else $error("protection bit went back to one");
  done_int_a: assert property ($fell(CMD_BUSY) |-> RAW_INT[0])
    else $error("finished operation raised no event");
  usec_load_a: assert property (USEC_WR |=> USEC_RELOAD == $past(USEC_DATA))
    else $error("microsecond count not loaded");
endmodule

bind fpt_ctrl fpt_ctrl_sva chk (.*);

//--- sim/fpt_host_model.sv
// Processor and debugger read requester in front of the controller.
// Assumes go, fetch and addr change just after a rising clock edge.
module fpt_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench commands
  input wire logic go,
  input wire logic fetch,
  input wire logic [12:0] addr,
  // Read request lines
  output logic req,
  output logic req_fetch,
  output logic [12:0] req_addr
);
  // Idle lines toggle so nothing leans on a stale address
  always @(posedge clk) begin
    req <= go && !rst;
    req_fetch <= go ? fetch : ~req_fetch;
    req_addr <= rst ? 13'h0 : (go ? addr : ~req_addr);
  end
endmodule

//--- sim/fpt_ctrl_tb_top.sv
// Self-checking bench for the flash protection and timing controller.
// Assumes a 100 MHz clock; microsecond count set to one clock per us.
module fpt_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK, RESET, CMD_REQ, CMD_COMMIT_PE, USEC_WR, PE_WR, RE_WR;
  logic go, go_fetch, RD_REQ, RD_FETCH, RD_VALID, RD_FAULT, CMD_BUSY, f;
  logic [12:0] go_addr, CMD_ADDR, RD_ADDR;
  logic [1:0] CMD_OP, INT_MASK, INT_CLEAR, RAW_INT, MASKED_INT;
  logic [7:0] USEC_DATA, USEC_RELOAD;
  logic [31:0] RD_DATA, CMD_DATA, PE_DATA, RE_DATA, PROGRAM_ENABLE;
  logic [31:0] READ_ENABLE, d;
  int mismatches, num_checks, cycles;
  logic [3:0] pe_exp = 4'b1010;
  logic [3:0] re_exp = 4'b1100;
  fpt_ctrl uut (.*);
  fpt_host_model host (.clk(CLOCK), .rst(RESET), .go(go), .fetch(go_fetch),
    .addr(go_addr), .req(RD_REQ), .req_fetch(RD_FETCH), .req_addr(RD_ADDR));
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge CLOCK);
    #1;
  endtask
  task automatic cmd(input logic [1:0] op, input logic [12:0] a,
      input logic [31:0] dat, input logic pe);
    {CMD_OP, CMD_ADDR, CMD_DATA, CMD_COMMIT_PE, CMD_REQ} = {op, a, dat, pe, 1'b1};
    INT_CLEAR = 2'h3;
    tick();
    CMD_REQ = 1'b0;
    INT_CLEAR = 2'h0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (CMD_BUSY === 1'b1 && n < 30000) begin
      tick();
      n++;
    end
    chk("done_int", RAW_INT[0], 1'b1);
  endtask
  task automatic rd(input logic fe, input logic [12:0] a);
    int n;
    {go, go_fetch, go_addr} = {1'b1, fe, a};
    tick();
    go = 1'b0;
    n = 0;
    do begin
      tick();
      n++;
    end while (RD_VALID !== 1'b1 && n < 6);
    chk("rd_valid", RD_VALID, 1'b1);
    f = RD_FAULT;
    d = RD_DATA;
  endtask
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      close_out();
    end
  end
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    RESET = 1'b1;
    {go, go_fetch, go_addr, CMD_REQ, CMD_OP, CMD_ADDR} = 0;
    {CMD_DATA, CMD_COMMIT_PE, USEC_WR, USEC_DATA, INT_MASK, INT_CLEAR} = 0;
    {PE_WR, PE_DATA, RE_WR, RE_DATA, mismatches, num_checks, cycles} = 0;
    repeat (5) tick();
    RESET = 1'b0;
    chk("usec_rst", USEC_RELOAD, 8'h31);
    chk("pe_rst", PROGRAM_ENABLE, 32'hffffffff);
    chk("re_rst", READ_ENABLE, 32'hffffffff);
    {USEC_WR, USEC_DATA, INT_MASK} = {1'b1, 8'h00, 2'h3};
    tick();
    USEC_WR = 1'b0;
    chk("usec", USEC_RELOAD, 8'h00);
    cmd(2'h2, 13'h000, 32'h0, 1'b0);
    wait_done();
    rd(1'b0, 13'h3fc);
    chk("erased", d, 32'hffffffff);
    cmd(2'h1, 13'h004, 32'h12345678, 1'b0);
    wait_done();
    cmd(2'h1, 13'h004, 32'hff00ff00, 1'b0);
    wait_done();
    rd(1'b0, 13'h004);
    chk("prog_and", d, 32'h12005600);
    INT_CLEAR = 2'h3;
    tick();
    INT_CLEAR = 2'h0;
    chk("int_clr", {MASKED_INT, RAW_INT}, 4'h0);
    {PE_WR, PE_DATA, RE_WR, RE_DATA} = {1'b1, 32'hfffffffa, 1'b1, 32'hfffffffc};
    tick();
    chk("pe_wr", PROGRAM_ENABLE, 32'hfffffffa);
    {PE_DATA, RE_WR} = {32'hffffffff, 1'b0};
    tick();
    PE_WR = 1'b0;
    chk("pe_set", PROGRAM_ENABLE, 32'hfffffffa);
    cmd(2'h2, 13'h400, 32'h0, 1'b0);
    chk("blk1_prot", CMD_BUSY, 1'b0);
    for (int u = 0; u < 4; u++) begin
      INT_CLEAR = 2'h3;
      tick();
      INT_CLEAR = 2'h0;
      rd(1'b0, 13'(u * 2048 + 8));
      chk("rd_fault", f, !re_exp[u]);
      rd(1'b1, 13'(u * 2048 + 8));
      chk("fetch", f, 1'b0);
      cmd(2'h1, 13'(u * 2048 + 8), 32'hffffffff, 1'b0);
      chk("prog_go", CMD_BUSY, pe_exp[u]);
      tick();
      chk("acc_int", MASKED_INT[1], !pe_exp[u]);
      if (pe_exp[u]) wait_done();
    end
    cmd(2'h3, 13'h000, 32'h0, 1'b1);
    tick();
    RESET = 1'b1;
    repeat (2) tick();
    RESET = 1'b0;
    chk("pe_kept", PROGRAM_ENABLE, 32'hfffffffa);
    chk("re_kept", READ_ENABLE, 32'hfffffffc);
    chk("usec_back", USEC_RELOAD, 8'h31);
    close_out();
  end
endmodule
